//--- design/wwd_prescaler.sv
// Counter clock divider of the watchdog: one tick per selected ratio.
// Assumes run and clear come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module wwd_prescaler
  import wwd_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  wwd_div_if.pre divPort
);

  initial begin
    if (DIV_W < 6 || DIV_W > 8) begin
      $error("wwd_prescaler: DIV_W must lie between 6 and 8");
    end
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } wwd_pre_s;

  wwd_pre_s st;
  wwd_pre_s next_st;
  logic [DIV_W-1:0] limit;

  always_comb begin
    limit = DIV_W'(DIV_LIMIT_TABLE[divPort.divSel]);
    next_st = st;
    next_st.tick = 1'b0;
    // [R6] Divider ratio select.
    if (divPort.clear) begin
      next_st.cnt = '0;
    end else if (divPort.run) begin
      if (st.cnt >= limit) begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign divPort.tick = st.tick;

endmodule
`default_nettype wire

//--- design/wwd_windowed_watchdog.sv
// Windowed independent watchdog with AXI4-Lite registers.
// Assumes sleepMode comes from logic on clk_sys; watchdogReset feeds the
// chip reset controller, which must not return it to rst_n of this block.
//
// Operation
// [R1] Refresh only inside window; else error.
// [R2] Error triggers reset or NMI per setting.
// [R3] NMI action sets watchdog source flag.
// [R4] Reset cause stays readable across reset.
// [R5] Counter halts in sleep unless overridden.
// [R6] Period and divider fixed before start.
// [R7] Valid refresh reloads counter and window.
// [R8] Counts from start until error or refresh.
`timescale 1ns/1ps
`default_nettype none
module wwd_windowed_watchdog
  import wwd_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sleepMode,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic watchdogReset,
  output logic watchdogNmi,
  output logic irq
);

  initial begin
    if (CNT_W < 15 || CNT_W > 16) begin
      $error("wwd_windowed_watchdog: CNT_W must be 15 or 16");
    end
    if ((1 << CNT_W) <= int'(PERIOD_TABLE[3])) begin
      $error("wwd_windowed_watchdog: CNT_W too narrow for the longest period");
    end
  end

  typedef struct packed {
    wwd_state_e state;
    logic action;
    logic sleepRun;
    logic [1:0] topSel;
    logic [1:0] divSel;
    logic [1:0] openSel;
    logic [1:0] closeSel;
    logic [CNT_W-1:0] count;
    logic [7:0] rstTimer;
    logic rstOut;
    logic nmiFlag;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [1:0] cause;
    logic irq;
    logic awRdy;
    logic wRdy;
    logic awHave;
    logic wHave;
    logic bValid;
    logic [1:0] bResp;
    logic [ADDR_W-1:0] awAddr;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic arRdy;
    logic rValid;
    logic [1:0] rResp;
    logic [DATA_W-1:0] rData;
  } wwd_regs_s;

  localparam wwd_regs_s REGS_RESET = '{
    state: WD_IDLE,
    awRdy: 1'b1,
    wRdy: 1'b1,
    arRdy: 1'b1,
    default: '0
  };

  wwd_regs_s st;
  wwd_regs_s next_st;

  wwd_div_if divIf ();

  logic [DATA_W-1:0] laneMask;
  logic [DATA_W-1:0] wEff;
  logic [DATA_W-1:0] ctrlRead;
  logic [DATA_W-1:0] ctrlNew;
  logic [DATA_W-1:0] countRead;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] quarter;
  logic [CNT_W-1:0] openLimit;
  logic [CNT_W-1:0] closeLimit;
  logic windowOpen;
  logic countEnable;
  logic doWrite;
  logic startReq;
  logic refreshReq;
  logic reload;
  logic nmiClr;
  logic [1:0] irqClr;
  logic [1:0] causeClr;
  logic [1:0] events;

  wwd_prescaler #(
    .DIV_W(6)
  ) prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .divPort(divIf.pre)
  );

  assign divIf.divSel = st.divSel;
  assign divIf.run = countEnable;
  assign divIf.clear = reload;

  always_comb begin
    next_st = st;
    laneMask = {{8{st.wStrb[3]}}, {8{st.wStrb[2]}}, {8{st.wStrb[1]}}, {8{st.wStrb[0]}}};
    wEff = st.wData & laneMask;
    startReq = 1'b0;
    refreshReq = 1'b0;
    reload = 1'b0;
    nmiClr = 1'b0;
    irqClr = 2'b00;
    causeClr = 2'b00;
    events = 2'b00;

    ctrlRead = CTRL_RESET;
    ctrlRead[CTRL_START_BIT] = (st.state == WD_RUN);
    ctrlRead[CTRL_ACTION_BIT] = st.action;
    ctrlRead[CTRL_SLEEP_RUN_BIT] = st.sleepRun;
    ctrlRead[CTRL_TOP_LSB +: 2] = st.topSel;
    ctrlRead[CTRL_DIV_LSB +: 2] = st.divSel;
    ctrlRead[CTRL_WOPEN_LSB +: 2] = st.openSel;
    ctrlRead[CTRL_WCLOSE_LSB +: 2] = st.closeSel;
    ctrlNew = (ctrlRead & ~laneMask) | wEff;

    // [R1] Window bounds.
    period = CNT_W'(PERIOD_TABLE[st.topSel]);
    quarter = period >> 2;
    openLimit = CNT_W'(quarter * (3'd4 - {1'b0, st.openSel}));
    closeLimit = CNT_W'(quarter * {1'b0, st.closeSel});
    windowOpen = (st.count < openLimit) && (st.count >= closeLimit);

    // [R5] Sleep halts counting.
    countEnable = (st.state == WD_RUN) && !(sleepMode && !st.sleepRun);

    countRead = DATA_W'(st.count);
    countRead[COUNT_STATE_LSB +: 2] = st.state;
    countRead[COUNT_WIN_BIT] = windowOpen && (st.state == WD_RUN);

    if (s_axi_awvalid && st.awRdy) begin
      next_st.awAddr = s_axi_awaddr;
      next_st.awHave = 1'b1;
      next_st.awRdy = 1'b0;
    end
    if (s_axi_wvalid && st.wRdy) begin
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
      next_st.wHave = 1'b1;
      next_st.wRdy = 1'b0;
    end

    doWrite = st.awHave && st.wHave;
    if (doWrite) begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = RESP_OKAY;
      unique case (st.awAddr)
        OFF_CTRL: begin
          // [R5] Sleep override.
          next_st.sleepRun = ctrlNew[CTRL_SLEEP_RUN_BIT];
          // [R6] Locked while counting.
          if (st.state == WD_IDLE) begin
            next_st.action = ctrlNew[CTRL_ACTION_BIT];
            next_st.topSel = ctrlNew[CTRL_TOP_LSB +: 2];
            next_st.divSel = ctrlNew[CTRL_DIV_LSB +: 2];
            next_st.openSel = ctrlNew[CTRL_WOPEN_LSB +: 2];
            next_st.closeSel = ctrlNew[CTRL_WCLOSE_LSB +: 2];
            startReq = ctrlNew[CTRL_START_BIT];
          end
        end
        OFF_REFRESH: begin
          refreshReq = |st.wStrb;
        end
        OFF_COUNT: begin
        end
        OFF_NMI_STATUS: begin
          nmiClr = wEff[NMI_SRC_BIT];
        end
        OFF_IRQ_STATUS: begin
          irqClr = wEff[1:0];
        end
        OFF_IRQ_MASK: begin
          next_st.irqMask = (st.irqMask & ~laneMask[1:0]) | wEff[1:0];
        end
        OFF_RESET_CAUSE: begin
          causeClr = wEff[1:0];
        end
        default: begin
          next_st.bResp = RESP_SLVERR;
        end
      endcase
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
      next_st.awRdy = 1'b1;
      next_st.wRdy = 1'b1;
    end

    if (s_axi_arvalid && st.arRdy) begin
      next_st.arRdy = 1'b0;
      next_st.rValid = 1'b1;
      next_st.rResp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL: next_st.rData = ctrlRead;
        OFF_REFRESH: next_st.rData = '0;
        OFF_COUNT: next_st.rData = countRead;
        OFF_NMI_STATUS: next_st.rData = DATA_W'(st.nmiFlag);
        OFF_IRQ_STATUS: next_st.rData = DATA_W'(st.irqStat);
        OFF_IRQ_MASK: next_st.rData = DATA_W'(st.irqMask);
        OFF_RESET_CAUSE: next_st.rData = DATA_W'(st.cause);
        default: begin
          next_st.rData = '0;
          next_st.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
      next_st.arRdy = 1'b1;
    end

    unique case (st.state)
      WD_IDLE: begin
        // [R8] Start loads counter.
        if (startReq) begin
          next_st.state = WD_RUN;
          next_st.count = CNT_W'(PERIOD_TABLE[next_st.topSel]) - 1'b1;
          reload = 1'b1;
        end
      end
      WD_RUN: begin
        // A refresh wins over a tick in the same cycle, so no reload is lost.
        if (refreshReq) begin
          // [R7] Reload on refresh.
          if (windowOpen) begin
            next_st.count = period - 1'b1;
            reload = 1'b1;
          end else begin
            // [R1] Misplaced refresh error.
            events[EV_BAD_REFRESH] = 1'b1;
          end
        end else if (divIf.tick && countEnable) begin
          // [R8] Continuous down count.
          if (st.count == '0) begin
            // [R1] Timeout error.
            events[EV_TIMEOUT] = 1'b1;
          end else begin
            next_st.count = st.count - 1'b1;
          end
        end
      end
      WD_RESET: begin
        if (st.rstTimer == 8'h00) begin
          next_st.rstOut = 1'b0;
          next_st.state = WD_IDLE;
        end else begin
          next_st.rstTimer = st.rstTimer - 8'h01;
        end
      end
      WD_HALT: begin
        // Stopped for good after an interrupt error; only rst_n leaves it.
      end
    endcase

    // [R2] Error action.
    if (|events) begin
      if (st.action == ACT_NMI) begin
        next_st.state = WD_HALT;
      end else begin
        // The reset returns the control fields to their power-up values so that
        // software runs the initialisation again; status, cause and irq mask keep theirs.
        next_st.state = WD_RESET;
        next_st.rstOut = 1'b1;
        next_st.rstTimer = RST_PULSE_CYCLES - 8'h01;
        next_st.action = ACT_RESET;
        next_st.sleepRun = 1'b0;
        next_st.topSel = 2'b00;
        next_st.divSel = 2'b00;
        next_st.openSel = 2'b00;
        next_st.closeSel = 2'b00;
      end
    end

    // [R3] Source flag, set wins.
    next_st.nmiFlag = (st.nmiFlag && !nmiClr) || ((|events) && st.action == ACT_NMI);
    // [R4] Sticky reset cause.
    next_st.cause = (st.cause & ~causeClr) | events;
    next_st.irqStat = (st.irqStat & ~irqClr) | events;
    next_st.irq = |(next_st.irqStat & next_st.irqMask);
  end

  // The cause bits are cleared only by rst_n, which must be the power-on
  // reset, and by writing ones to the reset cause register; an error reset never touches them.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= REGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awRdy;
  assign s_axi_wready = st.wRdy;
  assign s_axi_bresp = st.bResp;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_arready = st.arRdy;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;
  assign s_axi_rvalid = st.rValid;
  assign watchdogReset = st.rstOut;
  assign watchdogNmi = st.nmiFlag;
  assign irq = st.irq;

endmodule
`default_nettype wire

//--- include/wwd_div_if.sv
// Link between the watchdog core and its counter clock prescaler.
// Both ends sit on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface wwd_div_if;
  logic [1:0] divSel;
  logic run;
  logic clear;
  logic tick;
  modport ctrl (output divSel, output run, output clear, input tick);
  modport pre (input divSel, input run, input clear, output tick);
endinterface
`default_nettype wire

//--- include/wwd_pkg.sv
// Constants, register map and types of the windowed watchdog.
// Assumes a single system clock; all offsets are byte addresses on AXI4-Lite.
package wwd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REFRESH = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_NMI_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_RESET_CAUSE = 8'h18;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ACTION_BIT = 1;
  localparam int CTRL_SLEEP_RUN_BIT = 2;
  localparam int CTRL_TOP_LSB = 4;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_WOPEN_LSB = 12;
  localparam int CTRL_WCLOSE_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam int COUNT_STATE_LSB = 16;
  localparam int COUNT_WIN_BIT = 18;

  localparam int EV_TIMEOUT = 0;
  localparam int EV_BAD_REFRESH = 1;
  localparam int NMI_SRC_BIT = 0;

  localparam logic ACT_RESET = 1'b0;
  localparam logic ACT_NMI = 1'b1;

  // Timeout periods in counter ticks, indexed by the period select.
  localparam logic [3:0][15:0] PERIOD_TABLE = {16'h4000, 16'h2000, 16'h1000, 16'h0400};
  // Prescaler terminal values, giving ratios of 1, 4, 16 and 64.
  localparam logic [3:0][7:0] DIV_LIMIT_TABLE = {8'h3f, 8'h0f, 8'h03, 8'h00};

  localparam logic [7:0] RST_PULSE_CYCLES = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_RESET = 2'b11,
    WD_HALT = 2'b10
  } wwd_state_e;

endpackage

//--- verification/wwd_windowed_watchdog_monitor.sv
// Concurrent checks of the windowed watchdog, seen from its top ports.
// Assumes one clock, clk_sys, and a synchronous active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module wwd_windowed_watchdog_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watchdogReset,
  input wire logic watchdogNmi
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // The pulse is longer than a repetition may unroll, so it is counted here.
  logic [4:0] rstLen;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rstLen <= 5'h00;
    end else begin
      rstLen <= watchdogReset ? rstLen + 5'h01 : 5'h00;
    end
  end
  sequence s_wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_rstLen; $fell(watchdogReset) |-> rstLen == 5'h10; endproperty
  a_rstLen: assert property (p_rstLen)
    else $error("reset pulse length wrong");
  property p_rstMax; rstLen <= 5'h10; endproperty
  a_rstMax: assert property (p_rstMax)
    else $error("reset pulse too long");
  property p_noBoth; !(watchdogReset && watchdogNmi); endproperty
  a_noBoth: assert property (p_noBoth)
    else $error("reset and nmi together");
  property p_nmiClr; $fell(watchdogNmi) |-> $rose(s_axi_bvalid); endproperty
  a_nmiClr: assert property (p_nmiClr)
    else $error("nmi flag dropped without a write");
  property p_wrLat; s_wrTaken |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_wrLat: assert property (p_wrLat)
    else $error("write response timing wrong");
  property p_wrBlk; s_wrTaken |=> !s_axi_awready && !s_axi_wready; endproperty
  a_wrBlk: assert property (p_wrBlk)
    else $error("write channel open while busy");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold)
    else $error("write response not held");
  property p_rdLat; s_rdTaken |=> s_axi_rvalid; endproperty
  a_rdLat: assert property (p_rdLat)
    else $error("read data late");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold)
    else $error("read data not held");
endmodule
`default_nettype wire

//--- verification/wwd_windowed_watchdog_test.sv
// Self-checking bench of the windowed watchdog over AXI4-Lite.
// Assumes the monitor module is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module wwd_windowed_watchdog_test;
  import wwd_pkg::*;
  localparam logic [33:0] FULL = '1;
  logic clk_sys = 1'b0, rst_n = 1'b0, sleepMode = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic watchdogReset, watchdogNmi, irq;
  logic [33:0] expQ[$], mskQ[$], bQ[$];
  int err_total = 0, samples_checked = 0, cyc = 0, n;
  integer seed = 63;
  always #4 clk_sys = ~clk_sys;
  wwd_windowed_watchdog dut (.clk_sys, .rst_n, .sleepMode, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .watchdogReset, .watchdogNmi, .irq);
  task automatic conclude;
    $display("compared %0d mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bQ.push_back({32'h0, (a > OFF_RESET_CAUSE || a[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY});
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Each read leaves its expectation for the watcher below.
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge clk_sys) begin
    if (rst_n && s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata} & mskQ.pop_front(), expQ.pop_front());
    end
    if (rst_n && s_axi_bvalid && s_axi_bready) begin
      chk({32'h0, s_axi_bresp}, bQ.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(8'h1c, $random(seed));
    rd(OFF_CTRL, 34'h0, FULL);
    rd(8'h1c, {RESP_SLVERR, 32'h0}, FULL);
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_CTRL, 32'h3333);
    wr(OFF_REFRESH, $random(seed));
    rd(OFF_IRQ_STATUS, 34'h2, FULL);
    rd(OFF_NMI_STATUS, 34'h1, FULL);
    rd(OFF_RESET_CAUSE, 34'h2, FULL);
    rd(OFF_COUNT, 34'h23f00, 34'h3ff00);
    rd(OFF_CTRL, 34'h3332, FULL);
    chk(watchdogNmi, 34'h1);
    chk(irq, 34'h1);
    wr(OFF_NMI_STATUS, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk({watchdogNmi, irq}, 34'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(OFF_CTRL, 32'h1);
    repeat (300) @(posedge clk_sys);
    sleepMode <= 1'b1;
    wr(OFF_REFRESH, $random(seed));
    repeat (50) @(posedge clk_sys);
    rd(OFF_COUNT, 34'h503ff, 34'h7ffff);
    wr(OFF_CTRL, 32'h4);
    n = 0;
    while (!watchdogReset && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(watchdogReset, 34'h1);
    repeat (20) @(posedge clk_sys);
    rd(OFF_RESET_CAUSE, 34'h1, FULL);
    rd(OFF_IRQ_STATUS, 34'h1, FULL);
    rd(OFF_CTRL, 34'h0, FULL);
    rd(OFF_COUNT, 34'h0, 34'h30000);
    sleepMode <= 1'b0;
    chk(irq, 34'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (1) @(posedge clk_sys);
    chk(irq, 34'h1);
    wr(OFF_CTRL, 32'h20103);
    repeat (1000) @(posedge clk_sys);
    rd(OFF_COUNT, 34'h50000, 34'h70000);
    repeat (1300) @(posedge clk_sys);
    rd(OFF_COUNT, 34'h10000, 34'h70000);
    wr(OFF_REFRESH, $random(seed));
    rd(OFF_IRQ_STATUS, 34'h3, FULL);
    rd(OFF_RESET_CAUSE, 34'h3, FULL);
    chk(watchdogNmi, 34'h1);
    repeat (2) @(posedge clk_sys);
    conclude();
  end
endmodule
bind wwd_windowed_watchdog wwd_windowed_watchdog_monitor mon (.clk_sys, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .watchdogReset, .watchdogNmi);
`default_nettype wire
